//--- inc/sdg_pkg.sv
// shared constants, tables and types of the byte stream digest engine
package sdg_pkg;
    localparam int LEN_W = 61;
    localparam int CNT_W = 11;
    localparam int ADDR_W = 9;
    localparam int RAM_DEPTH = 512;
    localparam logic [9:0] RAM_FULL_WORDS = 10'h200;
    localparam logic [10:0] FILL_PAUSE_LEVEL = 11'h7c0;
    localparam logic [10:0] FILL_SATURATE = 11'h7ff;
    localparam logic [60:0] LEN_PAD_BYTES = 61'h8;
    localparam logic [31:0] PAD_MARKER = 32'h8000_0000;
    localparam logic [7:0] PAD_BYTE = 8'h80;
    localparam logic [5:0] LAST_ROUND = 6'h3f;
    // arbitrary value, no meaning beyond telling builds apart
    localparam logic [31:0] VERSION_WORD = 32'h0001_0000;

    // round constants of the compression function
    localparam logic [31:0] ROUND_K [0:63] = '{
        32'h428a_2f98, 32'h7137_4491, 32'hb5c0_fbcf, 32'he9b5_dba5, 32'h3956_c25b,
        32'h59f1_11f1, 32'h923f_82a4, 32'hab1c_5ed5, 32'hd807_aa98, 32'h1283_5b01,
        32'h2431_85be, 32'h550c_7dc3, 32'h72be_5d74, 32'h80de_b1fe, 32'h9bdc_06a7,
        32'hc19b_f174, 32'he49b_69c1, 32'hefbe_4786, 32'h0fc1_9dc6, 32'h240c_a1cc,
        32'h2de9_2c6f, 32'h4a74_84aa, 32'h5cb0_a9dc, 32'h76f9_88da, 32'h983e_5152,
        32'ha831_c66d, 32'hb003_27c8, 32'hbf59_7fc7, 32'hc6e0_0bf3, 32'hd5a7_9147,
        32'h06ca_6351, 32'h1429_2967, 32'h27b7_0a85, 32'h2e1b_2138, 32'h4d2c_6dfc,
        32'h5338_0d13, 32'h650a_7354, 32'h766a_0abb, 32'h81c2_c92e, 32'h9272_2c85,
        32'ha2bf_e8a1, 32'ha81a_664b, 32'hc24b_8b70, 32'hc76c_51a3, 32'hd192_e819,
        32'hd699_0624, 32'hf40e_3585, 32'h106a_a070, 32'h19a4_c116, 32'h1e37_6c08,
        32'h2748_774c, 32'h34b0_bcb5, 32'h391c_0cb3, 32'h4ed8_aa4a, 32'h5b9c_ca4f,
        32'h682e_6ff3, 32'h748f_82ee, 32'h78a5_636f, 32'h84c8_7814, 32'h8cc7_0208,
        32'h90be_fffa, 32'ha450_6ceb, 32'hbef9_a3f7, 32'hc671_78f2
    };

    // eight working words, a in the top lane
    typedef struct packed {
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] c;
        logic [31:0] d;
        logic [31:0] e;
        logic [31:0] f;
        logic [31:0] g;
        logic [31:0] h;
    } sdg_state_t;

    localparam sdg_state_t INIT_STATE = '{
        32'h6a09_e667, 32'hbb67_ae85, 32'h3c6e_f372, 32'ha54f_f53a,
        32'h510e_527f, 32'h9b05_688c, 32'h1f83_d9ab, 32'h5be0_cd19
    };

    typedef enum logic [2:0] {
        PK_IDLE = 3'b001,
        PK_MSG = 3'b010,
        PK_PAD = 3'b100
    } sdg_pk_state_t;

    typedef enum logic [2:0] {
        CR_IDLE = 3'b001,
        CR_ROUND = 3'b010,
        CR_FINAL = 3'b100
    } sdg_cr_state_t;
endpackage

//--- src/sdg_word_ram.sv
// word buffer memory with registered read data
`timescale 1ns/1ps
module sdg_word_ram
    import sdg_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic ce, // clock enable, freezes the memory when low
    input wire logic wr_en, // write one word
    input wire logic [ADDR_W-1:0] wr_addr, // write word address
    input wire logic [31:0] wr_data, // write word
    input wire logic rd_en, // start a read
    input wire logic [ADDR_W-1:0] rd_addr, // read word address
    output logic [31:0] rd_data // read word, one cycle after rd_en
);
    logic [31:0] mem [0:RAM_DEPTH-1];

    // write port
    always_ff @(posedge clk)
    begin
        if (ce && wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

    // read port, data held until the next read
    always_ff @(posedge clk)
    begin
        if (ce && rd_en)
        begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule

//--- src/sdg_engine.sv
// byte stream digest engine: byte packer, padding, word buffer and round core
//
// Functional notes
// - active-low synchronous reset clears control state and loads the initial hash; buffer and schedule data not reset
// - size counted in bytes, below two-to-sixty-one
// - busy high from load until digest done
// - takes exactly size bytes, hashes while arriving
// - each write strobe stores one byte while a message is open
// - empty flag tracks whole 32-bit words
// - 11-bit fill count moves in words
// - digest shown with one-cycle valid pulse
// - busy drops cycle after valid pulse
// - 65 cycles per 64-byte block
// - constant 32-bit version output
// - result is the standard 256-bit digest
`timescale 1ns/1ps
module sdg_engine
    import sdg_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic ce, // clock enable, all state frozen when low unless reset is asserted
    input wire logic core_reset_low, // synchronous reset, active low
    input wire logic msg_size_load, // one-cycle strobe that starts a message
    input wire logic [LEN_W-1:0] msg_size, // message length in bytes
    input wire logic byte_write_strobe, // one byte offered this cycle
    input wire logic [7:0] byte_write_value, // the byte
    output logic busy, // operation in progress
    output logic digest_valid, // one-cycle result strobe
    output logic [255:0] digest, // result, a word in the top bits
    output logic buffer_empty_flag, // no whole word buffered
    output logic [CNT_W-1:0] buffer_fill_count, // buffered bytes, word steps
    output logic [31:0] version // constant build number
);
    ////////////////////////////////////////////////////////////////////////////////
    // round functions
    function automatic logic [31:0] big_sig0(input logic [31:0] x);
        return {x[1:0], x[31:2]} ^ {x[12:0], x[31:13]} ^ {x[21:0], x[31:22]};
    endfunction

    function automatic logic [31:0] big_sig1(input logic [31:0] x);
        return {x[5:0], x[31:6]} ^ {x[10:0], x[31:11]} ^ {x[24:0], x[31:25]};
    endfunction

    function automatic logic [31:0] small_sig0(input logic [31:0] x);
        return {x[6:0], x[31:7]} ^ {x[17:0], x[31:18]} ^ {3'b000, x[31:3]};
    endfunction

    function automatic logic [31:0] small_sig1(input logic [31:0] x);
        return {x[16:0], x[31:17]} ^ {x[18:0], x[31:19]} ^ {10'h000, x[31:10]};
    endfunction

    function automatic sdg_state_t add_lanes(input sdg_state_t x, input sdg_state_t y);
        sdg_state_t s;
        s.a = x.a + y.a;
        s.b = x.b + y.b;
        s.c = x.c + y.c;
        s.d = x.d + y.d;
        s.e = x.e + y.e;
        s.f = x.f + y.f;
        s.g = x.g + y.g;
        s.h = x.h + y.h;
        return s;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // registers
    logic busy_reg;
    logic digest_valid_reg;
    logic empty_reg;
    logic [CNT_W-1:0] fill_reg;
    logic [31:0] version_reg;
    sdg_pk_state_t pk_state_reg;
    logic [LEN_W-1:0] len_reg;
    logic [LEN_W-1:0] remain_reg;
    logic [23:0] acc_reg;
    logic [1:0] nbyte_reg;
    logic marker_pending_reg;
    logic [59:0] widx_reg;
    logic [59:0] total_words_reg;
    logic [9:0] wcnt_reg;
    logic [ADDR_W-1:0] rd_ptr_reg;
    logic rd_pend_reg;
    logic [31:0] fb_mem_reg [0:1];
    logic fb_wp_reg;
    logic fb_rp_reg;
    logic [1:0] fb_cnt_reg;
    sdg_cr_state_t cr_state_reg;
    logic [5:0] round_reg;
    logic [55:0] blk_left_reg;
    sdg_state_t work_reg;
    sdg_state_t hash_reg;
    logic [31:0] w_reg [0:15];

    ////////////////////////////////////////////////////////////////////////////////
    // length load and block count; a load while busy is ignored
    wire logic load_ok = msg_size_load && !busy_reg;
    wire logic [61:0] len_plus = {1'b0, msg_size} + {1'b0, LEN_PAD_BYTES};
    wire logic [55:0] blocks_calc = len_plus[61:6] + 56'h1;
    wire logic [59:0] total_calc = {blocks_calc, 4'b0000};

    // byte packer: four bytes make one word, first byte on top
    wire logic pk_msg = (pk_state_reg == PK_MSG);
    wire logic pk_pad = (pk_state_reg == PK_PAD);
    wire logic byte_take = pk_msg && byte_write_strobe;
    wire logic last_byte = byte_take && (remain_reg == 61'h1);
    wire logic msg_word_wr = byte_take && (nbyte_reg == 2'b11);
    wire logic [31:0] msg_word = {acc_reg, byte_write_value};
    wire logic ram_full = (wcnt_reg == RAM_FULL_WORDS);

    // padding words: marker with leftover bytes, zeros, then bit length
    logic [31:0] marker_word;
    always_comb
    begin
        case (nbyte_reg)
            2'b00: marker_word = PAD_MARKER;
            2'b01: marker_word = {acc_reg[7:0], PAD_BYTE, 16'h0000};
            2'b10: marker_word = {acc_reg[15:0], PAD_BYTE, 8'h00};
            2'b11: marker_word = {acc_reg[23:0], PAD_BYTE};
            default: marker_word = PAD_MARKER;
        endcase
    end

    wire logic pad_wr = pk_pad && !ram_full; // pads stall on a full buffer
    wire logic len_hi_slot = (widx_reg == total_words_reg - 60'h2);
    wire logic len_lo_slot = (widx_reg == total_words_reg - 60'h1);
    wire logic pad_last = pad_wr && len_lo_slot;
    wire logic [31:0] pad_word = marker_pending_reg ? marker_word :
                                 len_hi_slot ? len_reg[60:29] :
                                 len_lo_slot ? {len_reg[28:0], 3'b000} : 32'h0000_0000;
    wire logic word_wr = msg_word_wr || pad_wr;
    wire logic [31:0] word_data = pad_wr ? pad_word : msg_word;

    // packer state machine
    always_ff @(posedge clk)
    begin
        if (!core_reset_low)
        begin
            pk_state_reg <= PK_IDLE;
            len_reg <= '0;
            remain_reg <= '0;
            acc_reg <= '0;
            nbyte_reg <= '0;
            marker_pending_reg <= 1'b0;
            widx_reg <= '0;
            total_words_reg <= '0;
        end
        else if (ce)
        begin
            if (word_wr)
            begin
                widx_reg <= widx_reg + 60'h1;
            end
            case (pk_state_reg)
                PK_IDLE:
                begin
                    if (load_ok)
                    begin
                        len_reg <= msg_size;
                        remain_reg <= msg_size;
                        total_words_reg <= total_calc;
                        widx_reg <= '0;
                        nbyte_reg <= '0;
                        marker_pending_reg <= 1'b1;
                        pk_state_reg <= (msg_size == '0) ? PK_PAD : PK_MSG;
                    end
                end
                PK_MSG:
                begin
                    if (byte_take)
                    begin
                        acc_reg <= {acc_reg[15:0], byte_write_value};
                        nbyte_reg <= nbyte_reg + 2'b01;
                        remain_reg <= remain_reg - 61'h1;
                    end
                    if (last_byte)
                    begin
                        pk_state_reg <= PK_PAD;
                    end
                end
                PK_PAD:
                begin
                    if (pad_wr)
                    begin
                        marker_pending_reg <= 1'b0;
                    end
                    if (pad_last)
                    begin
                        pk_state_reg <= PK_IDLE;
                    end
                end
                default: pk_state_reg <= PK_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // word buffer and two-entry skid buffer between memory and round core
    logic [31:0] ram_rd_data;
    wire logic core_wants = (cr_state_reg == CR_ROUND) && (round_reg[5:4] == 2'b00);
    wire logic fb_valid = (fb_cnt_reg != 2'b00);
    wire logic fb_pop = fb_valid && core_wants;
    wire logic fb_push = rd_pend_reg && (fb_cnt_reg != 2'b10);
    wire logic [31:0] fb_head = fb_mem_reg[fb_rp_reg];
    // count reads in flight so a stalled core never overflows the buffer
    wire logic [1:0] fb_claim = fb_cnt_reg + {1'b0, rd_pend_reg};
    wire logic rd_issue = (wcnt_reg != 10'h000) && (fb_pop ? (fb_claim != 2'b11) :
                          (fb_claim[1] == 1'b0));
    wire logic [9:0] wcnt_next = wcnt_reg + {9'h000, word_wr} - {9'h000, rd_issue};

    sdg_word_ram u_ram (
        .clk(clk),
        .ce(ce),
        .wr_en(word_wr),
        .wr_addr(widx_reg[ADDR_W-1:0]),
        .wr_data(word_data),
        .rd_en(rd_issue),
        .rd_addr(rd_ptr_reg),
        .rd_data(ram_rd_data)
    );

    // word count, status flags at word granularity
    always_ff @(posedge clk)
    begin
        if (!core_reset_low)
        begin
            wcnt_reg <= '0;
            rd_ptr_reg <= '0;
            rd_pend_reg <= 1'b0;
            empty_reg <= 1'b1;
            fill_reg <= '0;
        end
        else if (ce)
        begin
            wcnt_reg <= wcnt_next;
            rd_pend_reg <= rd_issue;
            rd_ptr_reg <= load_ok ? '0 : rd_ptr_reg + {8'h00, rd_issue};
            empty_reg <= (wcnt_next == 10'h000);
            fill_reg <= (wcnt_next == RAM_FULL_WORDS) ? FILL_SATURATE :
                        {wcnt_next[8:0], 2'b00};
        end
    end

    // skid buffer storage and pointers
    always_ff @(posedge clk)
    begin
        if (!core_reset_low)
        begin
            fb_wp_reg <= 1'b0;
            fb_rp_reg <= 1'b0;
            fb_cnt_reg <= '0;
        end
        else if (ce)
        begin
            if (fb_push)
            begin
                fb_mem_reg[fb_wp_reg] <= ram_rd_data;
                fb_wp_reg <= ~fb_wp_reg;
            end
            if (fb_pop)
            begin
                fb_rp_reg <= ~fb_rp_reg;
            end
            fb_cnt_reg <= fb_cnt_reg + {1'b0, fb_push} - {1'b0, fb_pop};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // round core: 64 rounds then one add cycle per block
    wire logic early_round = (round_reg[5:4] == 2'b00);
    wire logic core_step = (cr_state_reg == CR_ROUND) && (!early_round || fb_valid);
    wire logic [31:0] sched_word = small_sig1(w_reg[14]) + w_reg[9] + small_sig0(w_reg[1])
                                   + w_reg[0];
    wire logic [31:0] round_word = early_round ? fb_head : sched_word;
    wire logic [31:0] ch_val = (work_reg.e & work_reg.f) ^ (~work_reg.e & work_reg.g);
    wire logic [31:0] maj_val = (work_reg.a & work_reg.b) ^ (work_reg.a & work_reg.c)
                                ^ (work_reg.b & work_reg.c);
    wire logic [31:0] t1 = work_reg.h + big_sig1(work_reg.e) + ch_val + ROUND_K[round_reg]
                           + round_word;
    wire logic [31:0] t2 = big_sig0(work_reg.a) + maj_val;
    wire sdg_state_t block_sum = add_lanes(hash_reg, work_reg);
    wire logic last_block = (blk_left_reg == 56'h1);

    // message schedule window, oldest word at index 0
    always_ff @(posedge clk)
    begin
        if (ce && core_step)
        begin
            for (int i = 0; i < 15; i++)
            begin
                w_reg[i] <= w_reg[i + 1];
            end
            w_reg[15] <= round_word;
        end
    end

    // core state machine, busy and result strobe
    always_ff @(posedge clk)
    begin
        if (!core_reset_low)
        begin
            cr_state_reg <= CR_IDLE;
            round_reg <= '0;
            blk_left_reg <= '0;
            work_reg <= INIT_STATE;
            hash_reg <= INIT_STATE;
            busy_reg <= 1'b0;
            digest_valid_reg <= 1'b0;
            version_reg <= VERSION_WORD;
        end
        else if (ce)
        begin
            digest_valid_reg <= 1'b0;
            if (load_ok)
            begin
                busy_reg <= 1'b1;
            end
            else if (digest_valid_reg)
            begin
                busy_reg <= 1'b0;
            end
            case (cr_state_reg)
                CR_IDLE:
                begin
                    if (load_ok)
                    begin
                        blk_left_reg <= blocks_calc;
                        work_reg <= INIT_STATE;
                        hash_reg <= INIT_STATE;
                        round_reg <= '0;
                        cr_state_reg <= CR_ROUND;
                    end
                end
                CR_ROUND:
                begin
                    if (core_step)
                    begin
                        work_reg <= '{t1 + t2, work_reg.a, work_reg.b, work_reg.c,
                                      work_reg.d + t1, work_reg.e, work_reg.f, work_reg.g};
                        round_reg <= round_reg + 6'h01;
                        if (round_reg == LAST_ROUND)
                        begin
                            cr_state_reg <= CR_FINAL;
                        end
                    end
                end
                CR_FINAL:
                begin
                    hash_reg <= block_sum;
                    work_reg <= block_sum;
                    blk_left_reg <= blk_left_reg - 56'h1;
                    round_reg <= '0;
                    cr_state_reg <= last_block ? CR_IDLE : CR_ROUND;
                    digest_valid_reg <= last_block;
                end
                default: cr_state_reg <= CR_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs, each straight from a register
    assign busy = busy_reg;
    assign digest_valid = digest_valid_reg;
    assign digest = hash_reg;
    assign buffer_empty_flag = empty_reg;
    assign buffer_fill_count = fill_reg;
    assign version = version_reg;
endmodule

//--- testbench/sdg_engine_monitor.sv
// port-level checks of the byte stream digest engine
`timescale 1ns/1ps
module sdg_engine_monitor
    import sdg_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic ce, // clock enable
    input wire logic core_reset_low, // reset, active low
    input wire logic msg_size_load, // start strobe
    input wire logic busy, // operation in progress
    input wire logic digest_valid, // result strobe
    input wire logic buffer_empty_flag, // no whole word held
    input wire logic [CNT_W-1:0] buffer_fill_count, // held bytes
    input wire logic [31:0] version // build number
);
    default clocking @(posedge clk); endclocking
    default disable iff (!core_reset_low);

    ////////////////////////////////////////////////////////////////////////////////
    // reset must clear state even with the clock enable low
    a_reset_clear: assert property (disable iff (1'b0)
        !core_reset_low |=> !busy && !digest_valid && buffer_empty_flag && buffer_fill_count == '0)
        else $error("state not cleared by reset");
    a_load_busy: assert property (msg_size_load && !busy && ce |=> busy)
        else $error("busy did not follow an accepted load");
    a_busy_cause: assert property ($rose(busy) |-> $past(msg_size_load))
        else $error("busy rose without a load");
    a_valid_in_busy: assert property (digest_valid |-> busy)
        else $error("result strobe outside busy");
    a_valid_pulse: assert property (digest_valid && ce |=> !digest_valid)
        else $error("result strobe longer than one cycle");
    a_busy_drop: assert property (digest_valid && ce |=> !busy)
        else $error("busy still high after result strobe");
    a_busy_end_cause: assert property ($fell(busy) |-> $past(digest_valid))
        else $error("busy fell without a result");
    a_fill_words: assert property (buffer_fill_count[1:0] == 2'h0
        || buffer_fill_count == FILL_SATURATE) else $error("fill count not in word steps");
    a_empty_fill: assert property (buffer_empty_flag == (buffer_fill_count == '0))
        else $error("empty flag disagrees with fill count");
    a_version_const: assert property (version == VERSION_WORD)
        else $error("version output changed");
endmodule

bind sdg_engine sdg_engine_monitor u_mon (.clk(clk), .ce(ce), .core_reset_low(core_reset_low),
    .msg_size_load(msg_size_load), .busy(busy), .digest_valid(digest_valid),
    .buffer_empty_flag(buffer_empty_flag), .buffer_fill_count(buffer_fill_count),
    .version(version));

//--- testbench/sdg_feeder.sv
// user logic model that loads a length and streams message bytes
`timescale 1ns/1ps
module sdg_feeder
    import sdg_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic busy, // engine busy
    input wire logic [CNT_W-1:0] buffer_fill_count, // engine fill level
    output logic msg_size_load, // start strobe
    output logic [LEN_W-1:0] msg_size, // length in bytes
    output logic byte_write_strobe, // byte strobe
    output logic [7:0] byte_write_value // byte
);
    int seed = 89539;

    // idle lines carry the inverse of the last value, except msg_size, which keeps the stray load's value
    initial
    begin
        msg_size_load = 1'b0;
        msg_size = '0;
        byte_write_strobe = 1'b0;
        byte_write_value = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // byte patterns: counting letters, overlapping quads, or random
    function automatic logic [7:0] pick(input logic [1:0] mode, input logic [60:0] i);
        if (mode == 2'h0)
            return 8'h61 + i[7:0];
        if (mode == 2'h1)
            return 8'h61 + 8'(i[7:2]) + 8'(i[1:0]);
        return 8'($random(seed));
    endfunction

    // load then stream n bytes plus extra ones the engine must ignore
    task automatic send(input logic [60:0] n, input int extra, input logic [1:0] mode,
        input bit slow);
        logic [60:0] i;
        while (busy)
        begin
            @(posedge clk);
            #1;
        end
        msg_size_load = 1'b1;
        msg_size = n;
        @(posedge clk);
        #1;
        msg_size_load = 1'b0;
        msg_size = ~msg_size;
        i = '0;
        while (i < n + 61'(extra))
        begin
            // pause above the fill threshold so 64 bytes stay free
            if ((slow && ($random(seed) & 3) == 0) || buffer_fill_count > FILL_PAUSE_LEVEL)
            begin
                byte_write_strobe = 1'b0;
                byte_write_value = ~byte_write_value;
            end
            else
            begin
                byte_write_strobe = 1'b1;
                byte_write_value = pick(mode, i);
                i++;
            end
            @(posedge clk);
            #1;
        end
        byte_write_strobe = 1'b0;
        byte_write_value = ~byte_write_value;
    endtask

    // a load offered while busy, which the engine must refuse
    task automatic stray_load();
        @(posedge clk);
        #1;
        msg_size_load = 1'b1;
        msg_size = 61'h5;
        @(posedge clk);
        #1;
        msg_size_load = 1'b0;
    endtask
endmodule

//--- testbench/testbench.sv
// self-checking bench of the byte stream digest engine
`timescale 1ns/1ps
module testbench;
    import sdg_pkg::*;
    typedef struct packed {
        logic known;
        logic timed;
        logic [7:0] blocks;
        logic [255:0] value;
    } sdg_note_t;

    logic clk = 1'b0;
    logic ce = 1'b1;
    logic core_reset_low = 1'b0;
    logic msg_size_load, byte_write_strobe, busy, digest_valid, buffer_empty_flag;
    logic [LEN_W-1:0] msg_size;
    logic [7:0] byte_write_value;
    logic [255:0] digest;
    logic [CNT_W-1:0] buffer_fill_count;
    logic [31:0] version;
    logic valid_prev = 1'b0;
    logic after_valid = 1'b0;
    int failures = 0;
    int comparisons = 0;
    int cyc = 0;
    int t_load = 0;
    int lo;
    sdg_note_t notes[$];
    sdg_note_t note;

    always #4 clk = ~clk;

    sdg_engine dut (.clk(clk), .ce(ce), .core_reset_low(core_reset_low),
        .msg_size_load(msg_size_load), .msg_size(msg_size), .byte_write_strobe(byte_write_strobe),
        .byte_write_value(byte_write_value), .busy(busy), .digest_valid(digest_valid),
        .digest(digest), .buffer_empty_flag(buffer_empty_flag),
        .buffer_fill_count(buffer_fill_count), .version(version));

    sdg_feeder u_feed (.clk(clk), .busy(busy), .buffer_fill_count(buffer_fill_count),
        .msg_size_load(msg_size_load), .msg_size(msg_size),
        .byte_write_strobe(byte_write_strobe), .byte_write_value(byte_write_value));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [255:0] seen, input logic [255:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // note the expected result, then let the partner send the message
    task automatic hash(input logic [60:0] n, input int extra, input logic [1:0] mode,
        input logic known, input logic timed, input logic [255:0] v);
        notes.push_back('{known, timed, 8'((n + 61'h8) / 61'h40 + 61'h1), v});
        u_feed.send(n, extra, mode, !timed);
    endtask

    task automatic drain();
        for (int k = 0; k < 3000 && notes.size() != 0; k++)
            @(posedge clk);
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic idle_state();
        check("busy", busy, 1'b0);
        check("empty", buffer_empty_flag, 1'b1);
        check("fill", buffer_fill_count, 11'h000);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // watcher: takes the oldest note at each new result strobe
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        valid_prev <= digest_valid;
        after_valid <= digest_valid && !valid_prev;
        if (msg_size_load && !busy && ce && core_reset_low)
            t_load <= cyc;
        if (after_valid)
            check("busy_after", busy, 1'b0);
        if (digest_valid && !valid_prev)
        begin
            check("note_waiting", notes.size() != 0, 1'b1);
            note = notes.pop_front();
            lo = 65 * int'(note.blocks);
            if (note.known)
                check("digest", digest, note.value);
            if (note.timed)
                check("latency", cyc - t_load >= lo && cyc - t_load <= lo + 90, 1'b1);
        end
        if (cyc == 30000)
        begin
            failures++;
            finish_test();
        end
    end

    // main sequence
    initial
    begin
        repeat (4) @(posedge clk);
        #1;
        core_reset_low = 1'b1;
        @(posedge clk);
        #1;
        check("version", version, VERSION_WORD);
        check("digest_init", digest, INIT_STATE);
        idle_state();
        // three letters with stray bytes after them, then an empty message back to back
        hash(61'h3, 3, 2'h0, 1'b1, 1'b1, 256'hba78_16bf_8f01_cfea_4141_40de_5dae_2223_b003_61a3_9617_7a9c_b410_ff61_f200_15ad);
        hash(61'h0, 0, 2'h0, 1'b1, 1'b1, 256'he3b0_c442_98fc_1c14_9afb_f4c8_996f_b924_27ae_41e4_649b_934c_a495_991b_7852_b855);
        // two-block message with gaps, after a refused load offered while the empty message is hashed
        fork
            hash(61'd56, 0, 2'h1, 1'b1, 1'b0, 256'h248d_6a61_d206_38b8_e5c0_2693_0c3e_6039_a33c_e459_64ff_2167_f6ec_edd4_19db_06c1);
            begin
                repeat (30) @(posedge clk);
                u_feed.stray_load();
            end
        join
        hash(61'd200, 0, 2'h2, 1'b0, 1'b1, '0);
        // clock enable dropped while the empty message is hashed
        fork
            hash(61'h0, 0, 2'h0, 1'b1, 1'b0, 256'he3b0_c442_98fc_1c14_9afb_f4c8_996f_b924_27ae_41e4_649b_934c_a495_991b_7852_b855);
            begin
                // the long message must finish first, so the stall lands in the empty one
                wait (!busy);
                repeat (20) @(posedge clk);
                #1;
                ce = 1'b0;
                repeat (5) @(posedge clk);
                #1;
                ce = 1'b1;
            end
        join
        drain();
        // reset in mid-message; later bytes fall outside any message
        fork
            u_feed.send(61'd150, 0, 2'h2, 1'b1);
            begin
                repeat (40) @(posedge clk);
                #1;
                core_reset_low = 1'b0;
                repeat (3) @(posedge clk);
                #1;
                core_reset_low = 1'b1;
            end
        join
        repeat (2) @(posedge clk);
        #1;
        idle_state();
        hash(61'h3, 0, 2'h0, 1'b1, 1'b1, 256'hba78_16bf_8f01_cfea_4141_40de_5dae_2223_b003_61a3_9617_7a9c_b410_ff61_f200_15ad);
        drain();
        check("notes_left", notes.size(), 0);
        finish_test();
    end
endmodule
